// ---- src/hbia_cfg.svh ----
// Purpose: Constants for the host bus interface and arbiter block
// Assumes: 10 MHz system clock
// Notes: Status codes are the active-low cycle status lines as a 3-bit value
`ifndef HBIA_CFG_SVH
`define HBIA_CFG_SVH

// ****************************************
// Cycle status encodings {s2,s1,s0}
// ****************************************
`define HBIA_ST_LFETCH 3'h0
`define HBIA_ST_LREAD 3'h1
`define HBIA_ST_LWRITE 3'h2
`define HBIA_ST_HALT 3'h3
`define HBIA_ST_SFETCH 3'h4
`define HBIA_ST_SREAD 3'h5
`define HBIA_ST_SWRITE 3'h6
`define HBIA_ST_PASSIVE 3'h7

// ****************************************
// Clock divider and boot address
// ****************************************
`define HBIA_CLK_DIV 2'h3
`define HBIA_BOOT_ADDR 20'hF_FFF6
`define HBIA_RST_CYCLES 4'h8
// Idle level of every synchronised pin, in synchroniser bit order
`define HBIA_SYNC_IDLE 13'h171D

`endif

// ---- src/hbia_pkg.sv ----
// Purpose: Types for the host bus interface and arbiter block
// Assumes: Constants come from hbia_cfg.svh
// Notes: Types only
package hbia_pkg;

    // Arbiter states
    typedef enum logic [1:0]
    {
        HBIA_ARB_IDLE,
        HBIA_ARB_REQ,
        HBIA_ARB_OWN
    } hbia_arb_e;

    // Cycle status value
    typedef logic [2:0] hbia_status_t;

endpackage : hbia_pkg

// ---- src/hbia_top.sv ----
// Purpose: Processor reset, command decode, bus arbitration, data steering
// Assumes: One 15 MHz oscillator clock is not used; clk runs at 10 MHz and
//          the processor clock is a divide-by-three enable output
// Notes: Far-side pins pass a two-flop synchroniser before use
`timescale 1ns/1ps
`include "hbia_cfg.svh"

// ****************************************
// Top module
// ****************************************
// Overview of operation
// - Reset restarts processor, clears latch, control
// - First attention boots, later ones read blocks
// - Selector bit marks system or local cycle
// - Status lines decode to bus commands
// - Local commands reach ROM, RAM, decoders
// - Byte or word fetch, bit0 steers swap
// - Processor clock is input divided by three
// - Reset issued at power-up, init, board reset
// - Target ready synchronised before processor sees it
// - Request bus when system cycle needs it
// - Assert busy once granted
// - Address enable gates system commands and ready, lane enables
// - Strap chooses higher-only or any release
// - Address strobe loads system and local latches
// - Direction high outward, low inward
// - System enable high, local enable low
// - Low, high and swap data lanes
// - Swap only for byte mode access
// - Separate lane enables, low from bit0
module hbia_top
    import hbia_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Board reset and attention from the wake-up decoder
    input wire logic board_rst_n,
    input wire logic channel_attention_in,
    // Processor cycle status and address
    input wire logic cycle_status_0_n,
    input wire logic cycle_status_1_n,
    input wire logic cycle_status_2_n,
    input wire logic internal_addr_bit0,
    input wire logic byte_mode,
    input wire logic addr_strobe_in,
    // System bus arbitration pins
    input wire logic bus_priority_in_n,
    input wire logic bus_busy_in_n,
    input wire logic other_request_n,
    input wire logic higher_request_n,
    input wire logic any_request_strap,
    // Ready sources
    input wire logic xfer_ack_n,
    input wire logic port_ready,
    // Processor side outputs
    output logic io_processor_rst_n,
    output logic io_processor_clk,
    output logic channel_attention,
    output logic boot_fetch,
    output logic processor_ready,
    output logic system_select,
    // Commands
    output logic mem_read_cmd_n,
    output logic mem_write_cmd_n,
    output logic io_read_cmd_n,
    output logic advanced_io_write_cmd_n,
    output logic int_ack_cmd_n,
    // Arbitration outputs
    output logic bus_request_n,
    output logic bus_busy_n,
    output logic bus_busy_oe_n,
    output logic address_enable_n,
    // Data path steering
    output logic sys_latch_strobe,
    output logic local_latch_strobe,
    output logic transmit_receive_dir,
    output logic system_data_enable,
    output logic local_data_enable_n,
    output logic high_lane_enable_n,
    output logic low_lane_enable_n,
    output logic swap_lane_enable_n,
    output logic system_addr_bit0_n
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int NS = 13;
    logic [NS-1:0] raw_in;
    logic [NS-1:0] sync1_r;  // First stage, read only by stage two
    logic [NS-1:0] sync2_r;  // Stable copies
    logic [NS-1:0] sync1_nxt;
    logic [NS-1:0] sync2_nxt;

    assign raw_in = {board_rst_n, channel_attention_in, cycle_status_2_n,
                     cycle_status_1_n, cycle_status_0_n, internal_addr_bit0,
                     byte_mode, addr_strobe_in, bus_priority_in_n,
                     other_request_n, higher_request_n, any_request_strap,
                     xfer_ack_n};

    // Two flops per pin; ready also passes here
    always_comb
    begin
        sync1_nxt = raw_in;
        sync2_nxt = sync1_r;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // Idle pin levels, so no false strobe follows reset
            sync1_r <= `HBIA_SYNC_IDLE;
            sync2_r <= `HBIA_SYNC_IDLE;
        end
        else
        begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
        end
    end

    // Named views of the synchronised pins
    logic s_brst_n, s_ca, s_a0, s_byte, s_ale, s_prio_n;
    logic s_other_n, s_higher_n, s_any, s_xack_n;
    hbia_status_t s_st;
    assign s_brst_n = sync2_r[12];
    assign s_ca = sync2_r[11];
    assign s_st = sync2_r[10:8];
    assign s_a0 = sync2_r[7];
    assign s_byte = sync2_r[6];
    assign s_ale = sync2_r[5];
    assign s_prio_n = sync2_r[4];
    assign s_other_n = sync2_r[3];
    assign s_higher_n = sync2_r[2];
    assign s_any = sync2_r[1];
    assign s_xack_n = sync2_r[0];

    // Port ready is same-domain on-board logic; still registered once
    logic pready_r, pready_nxt;

    // ****************************************
    // Helper functions
    // ****************************************
    // True for the three system-space cycle codes
    function automatic logic is_system(input hbia_status_t st);
        is_system = (st == `HBIA_ST_SFETCH) || (st == `HBIA_ST_SREAD)
                    || (st == `HBIA_ST_SWRITE);
    endfunction : is_system

    // True for any cycle that moves data
    function automatic logic is_active(input hbia_status_t st);
        is_active = (st != `HBIA_ST_HALT) && (st != `HBIA_ST_PASSIVE);
    endfunction : is_active

    // ****************************************
    // Clock divider and reset generator
    // ****************************************
    logic [1:0] div_r, div_nxt;
    logic pclk_r, pclk_nxt;
    logic [3:0] rstcnt_r, rstcnt_nxt;
    logic prst_n_r, prst_n_nxt;

    // Divide by three; one-third duty like the original generator
    always_comb
    begin
        div_nxt = (div_r == `HBIA_CLK_DIV - 2'h1) ? 2'h0 : div_r + 2'h1;
        pclk_nxt = (div_nxt == 2'h0);
    end

    // Reset held after power-up or any board reset, then released
    // Holding it restarts firmware and clears control logic
    always_comb
    begin
        if (!s_brst_n)
            rstcnt_nxt = `HBIA_RST_CYCLES;
        else if (rstcnt_r != 4'h0)
            rstcnt_nxt = rstcnt_r - 4'h1;
        else
            rstcnt_nxt = 4'h0;
        prst_n_nxt = (rstcnt_nxt == 4'h0);
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            div_r <= 2'h0;
            pclk_r <= 1'b0;
            rstcnt_r <= `HBIA_RST_CYCLES;
            prst_n_r <= 1'b0;
        end
        else
        begin
            div_r <= div_nxt;
            pclk_r <= pclk_nxt;
            rstcnt_r <= rstcnt_nxt;
            prst_n_r <= prst_n_nxt;
        end
    end

    // ****************************************
    // Channel attention tracking
    // ****************************************
    logic booted_r, booted_nxt;
    logic ca_r, ca_nxt;
    logic boot_r, boot_nxt;

    // First attention after reset flags a boot fetch; later ones do not
    always_comb
    begin
        ca_nxt = s_ca && prst_n_r;
        booted_nxt = booted_r;
        boot_nxt = boot_r;
        if (!prst_n_r)
        begin
            booted_nxt = 1'b0;  // Reset forgets the link
            boot_nxt = 1'b0;
        end
        else if (s_ca && !ca_r)
        begin
            boot_nxt = !booted_r;  // Boot fetch only on first
            booted_nxt = 1'b1;
        end
    end

    // ****************************************
    // Arbiter
    // ****************************************
    hbia_arb_e arb_r, arb_nxt;
    logic release_req;

    // Strap picks which requesters can pull the bus away
    assign release_req = s_any ? (!s_other_n || !s_higher_n) : !s_higher_n;

    always_comb
    begin
        arb_nxt = arb_r;
        case (arb_r)
            HBIA_ARB_IDLE:
                if (is_system(s_st))
                    arb_nxt = HBIA_ARB_REQ;  // Need bus, not holding
            HBIA_ARB_REQ:
                if (!s_prio_n)
                    arb_nxt = HBIA_ARB_OWN;  // Host grant
            HBIA_ARB_OWN:
                // Hold between cycles until someone eligible asks
                if (!is_system(s_st) && release_req)
                    arb_nxt = HBIA_ARB_IDLE;
            default:
                arb_nxt = HBIA_ARB_IDLE;
        endcase
        if (!prst_n_r)
            arb_nxt = HBIA_ARB_IDLE;
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    logic [4:0] cmd_nxt;   // {mrd,mwt,ior,aiow,inta}, active low
    logic own;
    logic sysc;
    logic swap;

    assign own = (arb_nxt == HBIA_ARB_OWN);
    assign sysc = is_system(s_st);
    // Swap for byte access at an odd address
    assign swap = s_byte && s_a0;

    // Commands; system ones gated by address enable
    always_comb
    begin
        cmd_nxt = 5'h1F;
        case (s_st)
            `HBIA_ST_SFETCH, `HBIA_ST_SREAD:
                cmd_nxt[4] = !own;
            `HBIA_ST_SWRITE:
                cmd_nxt[3] = !own;
            `HBIA_ST_LREAD:
                cmd_nxt[2] = 1'b0;  // ROM and RAM read
            `HBIA_ST_LWRITE:
                cmd_nxt[1] = 1'b0;  // RAM write, decoder enable
            `HBIA_ST_LFETCH:
                cmd_nxt[0] = 1'b0;
            default:
                cmd_nxt = 5'h1F;    // Halt and passive issue nothing
        endcase
        // Next reset level, so no command shares a cycle with reset
        if (!prst_n_nxt)
            cmd_nxt = 5'h1F;
        pready_nxt = port_ready;
    end

    logic [4:0] cmd_r;
    logic sel_r, ready_r, dir_r, den_r, local_data_enable_n_n_r, ale_r;
    logic hi_n_r, lo_n_r, sw_n_r, a0_n_r;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            booted_r <= 1'b0;
            ca_r <= 1'b0;
            boot_r <= 1'b0;
            arb_r <= HBIA_ARB_IDLE;
            pready_r <= 1'b0;
            cmd_r <= 5'h1F;
            sel_r <= 1'b0;
            ready_r <= 1'b0;
            dir_r <= 1'b0;
            den_r <= 1'b0;
            local_data_enable_n_n_r <= 1'b1;
            ale_r <= 1'b0;
            hi_n_r <= 1'b1;
            lo_n_r <= 1'b1;
            sw_n_r <= 1'b1;
            a0_n_r <= 1'b1;
        end
        else
        begin
            booted_r <= booted_nxt;
            ca_r <= ca_nxt;
            boot_r <= boot_nxt;
            arb_r <= arb_nxt;
            pready_r <= pready_nxt;
            cmd_r <= cmd_nxt;
            sel_r <= sysc;  // System or local target
            // Ready: external ack on system cycles, port on local
            ready_r <= sysc ? (!s_xack_n && own) : pready_r;
            // Outward on writes
            dir_r <= (s_st == `HBIA_ST_SWRITE) || (s_st == `HBIA_ST_LWRITE);
            den_r <= sysc && own;
            local_data_enable_n_n_r <= !(is_active(s_st) && !sysc);
            ale_r <= s_ale;  // One strobe feeds both latches
            // Three lanes, each with its own enable
            hi_n_r <= !(sysc && own && !swap && (!s_byte || s_a0));
            lo_n_r <= !(sysc && own && !s_a0);
            sw_n_r <= !(sysc && own && swap);
            a0_n_r <= !s_a0;
        end
    end

    // ****************************************
    // Output assignments from flops
    // ****************************************
    assign io_processor_rst_n = prst_n_r;
    assign io_processor_clk = pclk_r;
    assign channel_attention = ca_r;
    assign boot_fetch = boot_r;
    assign processor_ready = ready_r;
    assign system_select = sel_r;
    assign mem_read_cmd_n = cmd_r[4];
    assign mem_write_cmd_n = cmd_r[3];
    assign io_read_cmd_n = cmd_r[2];
    assign advanced_io_write_cmd_n = cmd_r[1];
    assign int_ack_cmd_n = cmd_r[0];
    // Request only while waiting; busy while owning
    logic req_n_r, busy_n_r, aen_n_r;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            req_n_r <= 1'b1;
            busy_n_r <= 1'b1;
            aen_n_r <= 1'b1;
        end
        else
        begin
            req_n_r <= !(arb_nxt == HBIA_ARB_REQ);
            busy_n_r <= !own;
            aen_n_r <= !own;
        end
    end
    assign bus_request_n = req_n_r;
    assign bus_busy_n = busy_n_r;
    assign bus_busy_oe_n = busy_n_r;  // Open drain: drive only low
    assign address_enable_n = aen_n_r;
    assign sys_latch_strobe = ale_r;
    assign local_latch_strobe = ale_r;
    assign transmit_receive_dir = dir_r;
    assign system_data_enable = den_r;
    assign local_data_enable_n = local_data_enable_n_n_r;
    assign high_lane_enable_n = hi_n_r;
    assign low_lane_enable_n = lo_n_r;
    assign swap_lane_enable_n = sw_n_r;
    assign system_addr_bit0_n = a0_n_r;

endmodule : hbia_top

// ---- verification/hbia_host_model.sv ----
// Purpose: Host side model: bus priority resolver and memory acknowledge
// Assumes: One clock; grant and acknowledge follow a short or long delay
// Notes: The acknowledge line is pulled up, so it reads high when released
`timescale 1ns/1ps
module hbia_host_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Board side
    input wire logic bus_request_n,
    input wire logic mem_read_cmd_n,
    input wire logic mem_write_cmd_n,
    // Slow answers when high
    input wire logic slow,
    // Host side
    output logic bus_priority_in_n,
    output logic xfer_ack_n
);
    // ****************************************
    // Delay counters
    // ****************************************
    logic [3:0] gcnt_r; // Cycles the request has stood
    logic [3:0] acnt_r; // Cycles a memory command has stood
    // Counters saturate so a long hold never wraps into a false drop
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gcnt_r <= 4'h0;
            acnt_r <= 4'h0;
        end
        else
        begin
            gcnt_r <= bus_request_n ? 4'h0 : gcnt_r + {3'h0, gcnt_r != 4'hf};
            acnt_r <= (mem_read_cmd_n & mem_write_cmd_n) ? 4'h0 :
                acnt_r + {3'h0, acnt_r != 4'hf};
        end
    end
    // Grant by pulling priority low once the request has waited
    assign bus_priority_in_n = !(gcnt_r >= (slow ? 4'h8 : 4'h2));
    // Acknowledge once memory has taken or produced the data
    assign xfer_ack_n = !(acnt_r >= (slow ? 4'h6 : 4'h1));
endmodule : hbia_host_model

// ---- verification/hbia_top_chk.sv ----
// Purpose: Port assertions for the host bus interface block
// Assumes: One clock, asynchronous active-high reset
// Notes: Attached to every hbia_top by the bind at the foot
`timescale 1ns/1ps
module hbia_top_chk
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Watched inputs
    input wire logic cycle_status_0_n,
    input wire logic cycle_status_1_n,
    input wire logic cycle_status_2_n,
    input wire logic bus_priority_in_n,
    // Watched outputs
    input wire logic io_processor_rst_n,
    input wire logic io_processor_clk,
    input wire logic mem_read_cmd_n,
    input wire logic mem_write_cmd_n,
    input wire logic io_read_cmd_n,
    input wire logic advanced_io_write_cmd_n,
    input wire logic int_ack_cmd_n,
    input wire logic bus_request_n,
    input wire logic bus_busy_n,
    input wire logic address_enable_n,
    input wire logic transmit_receive_dir,
    input wire logic system_data_enable,
    input wire logic local_data_enable_n,
    input wire logic low_lane_enable_n,
    input wire logic swap_lane_enable_n
);
    // ****************************************
    // Helpers and properties
    // ****************************************
    // Status pins show a system fetch, read or write
    wire logic sys_st = cycle_status_2_n &
        ~(cycle_status_1_n & cycle_status_0_n);
    // No command of any kind
    wire logic cmd_idle = mem_read_cmd_n & mem_write_cmd_n & io_read_cmd_n &
        advanced_io_write_cmd_n & int_ack_cmd_n;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    property p_clk_div;
        $rose(io_processor_clk) |=>
            !io_processor_clk [*2] ##1 io_processor_clk;
    endproperty
    a_clk_div: assert property (p_clk_div)
        else $error("Processor clock is not one in three");
    property p_rst_quiet;
        !io_processor_rst_n |-> cmd_idle;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("Command issued while processor held in reset");
    property p_req;
        $fell(bus_request_n) |-> $past(sys_st, 3);
    endproperty
    a_req: assert property (p_req)
        else $error("Bus request without a system cycle");
    property p_grant;
        $fell(bus_busy_n) |-> !$past(bus_priority_in_n, 2);
    endproperty
    a_grant: assert property (p_grant)
        else $error("Bus taken without priority grant");
    property p_own;
        !(mem_read_cmd_n & mem_write_cmd_n) |->
            !address_enable_n && system_data_enable;
    endproperty
    a_own: assert property (p_own)
        else $error("Memory command without address enable");
    property p_busy;
        !address_enable_n |-> !bus_busy_n;
    endproperty
    a_busy: assert property (p_busy)
        else $error("Address enable while bus not busy");
    property p_excl;
        system_data_enable |-> local_data_enable_n;
    endproperty
    a_excl: assert property (p_excl)
        else $error("System and local transceivers both enabled");
    property p_dir_w;
        !mem_write_cmd_n |-> transmit_receive_dir;
    endproperty
    a_dir_w: assert property (p_dir_w)
        else $error("Write with inward direction");
    property p_dir_r;
        !(mem_read_cmd_n & io_read_cmd_n) |-> !transmit_receive_dir;
    endproperty
    a_dir_r: assert property (p_dir_r)
        else $error("Read with outward direction");
    property p_swap;
        !swap_lane_enable_n |-> low_lane_enable_n;
    endproperty
    a_swap: assert property (p_swap)
        else $error("Swap and low lanes both enabled");
    c_own: cover property ($fell(bus_busy_n));
    c_swap: cover property (!swap_lane_enable_n);
    c_iord: cover property (!io_read_cmd_n);
endmodule : hbia_top_chk
bind hbia_top hbia_top_chk u_chk (.*);

// ---- verification/tb.sv ----
// Purpose: Self-checking bench for the host bus interface block
// Assumes: 10 MHz clock; status driven as {s2,s1,s0}
// Notes: Fixed waits follow the three-edge pin to output latency
`timescale 1ns/1ps
`include "hbia_cfg.svh"
module tb;
    import hbia_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic clk, sys_rst, board_rst_n, channel_attention_in, byte_mode;
    logic cycle_status_0_n, cycle_status_1_n, cycle_status_2_n;
    logic internal_addr_bit0, addr_strobe_in, bus_priority_in_n;
    logic bus_busy_in_n, other_request_n, higher_request_n, slow;
    logic any_request_strap, xfer_ack_n, port_ready;
    logic io_processor_rst_n, io_processor_clk, channel_attention;
    logic boot_fetch, processor_ready, system_select, mem_read_cmd_n;
    logic mem_write_cmd_n, io_read_cmd_n, advanced_io_write_cmd_n;
    logic int_ack_cmd_n, bus_request_n, bus_busy_n, bus_busy_oe_n;
    logic address_enable_n, sys_latch_strobe, local_latch_strobe;
    logic transmit_receive_dir, system_data_enable, local_data_enable_n;
    logic high_lane_enable_n, low_lane_enable_n, swap_lane_enable_n;
    logic system_addr_bit0_n;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    // Grouped views used by the checks
    wire logic [4:0] cmds = {mem_read_cmd_n, mem_write_cmd_n, io_read_cmd_n,
        advanced_io_write_cmd_n, int_ack_cmd_n};
    wire logic [7:0] dv = {cmds, transmit_receive_dir, system_data_enable,
        local_data_enable_n};
    wire logic [7:0] lv = {1'h0, bus_busy_oe_n, system_addr_bit0_n,
        high_lane_enable_n, low_lane_enable_n, swap_lane_enable_n,
        sys_latch_strobe, local_latch_strobe};
    wire logic [7:0] own = {6'h0, bus_busy_n, address_enable_n};
    wire logic [7:0] sr = {6'h0, system_select, processor_ready};
    hbia_top dut (.*);
    hbia_host_model u_host
    (
        .clk(clk), .sys_rst(sys_rst), .bus_request_n(bus_request_n),
        .mem_read_cmd_n(mem_read_cmd_n), .mem_write_cmd_n(mem_write_cmd_n),
        .slow(slow), .bus_priority_in_n(bus_priority_in_n),
        .xfer_ack_n(xfer_ack_n)
    );
    // ****************************************
    // Helpers
    // ****************************************
    always #50 clk = ~clk;
    // Cut a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] e, input logic [7:0] a);
        cmp_count++;
        if (a !== e)
        begin
            miscompares++;
            $display("FAIL t=%0t exp=%h act=%h", $time, e, a);
        end
    endtask : chk
    task automatic st(input hbia_status_t c);
        @(posedge clk);
        {cycle_status_2_n, cycle_status_1_n, cycle_status_0_n} <= c;
    endtask : st
    // Let n edges pass, then sample where outputs have settled
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : w
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        w(2);
        chk(8'h00, {7'h0, io_processor_rst_n});
        chk(8'h1f, {3'h0, cmds});
        w(9);
        chk(8'h01, {7'h0, io_processor_rst_n});
    endtask : t_reset
    task automatic t_clk();
        int n = 0;
        repeat (30)
        begin
            @(negedge clk);
            n += io_processor_clk;
        end
        chk(8'h0a, 8'(n));
    endtask : t_clk
    task automatic t_ca();
        @(posedge clk);
        channel_attention_in <= 1'b1;
        w(4);
        chk(8'h03, {6'h0, channel_attention, boot_fetch});
        @(posedge clk);
        channel_attention_in <= 1'b0;
        w(4);
        chk(8'h01, {6'h0, channel_attention, boot_fetch});
        @(posedge clk);
        channel_attention_in <= 1'b1;
        w(4);
        chk(8'h02, {6'h0, channel_attention, boot_fetch});
        @(posedge clk);
        channel_attention_in <= 1'b0;
    endtask : t_ca
    // Every status code with expected command; direction and enables for all but halt and passive
    task automatic t_dec();
        logic [7:0] ex [8] = '{8'hf0, 8'hd8, 8'hec, 8'h00, 8'h7b, 8'h7b,
            8'hbf, 8'h00};
        for (int c = 0; c < 8; c++)
        begin
            st(3'(c));
            w(18);
            if (c == 3 || c == 7)
                chk(8'h1f, {3'h0, cmds});
            else
            begin
                chk(ex[c], dv);
                chk({6'h0, c[2], 1'b1}, sr);
            end
            // Local cycles: ready must follow the on-board port
            if (c < 3)
            begin
                @(posedge clk);
                port_ready <= 1'b0;
                w(3);
                chk(8'h00, sr);
                @(posedge clk);
                port_ready <= 1'b1;
            end
            st(`HBIA_ST_PASSIVE);
            w(6);
        end
        chk(8'h00, own);
    endtask : t_dec
    task automatic t_rel();
        @(posedge clk);
        other_request_n <= 1'b0;
        w(8);
        chk(8'h00, own);
        @(posedge clk);
        higher_request_n <= 1'b0;
        w(6);
        chk(8'h03, own);
        @(posedge clk);
        higher_request_n <= 1'b1;
        other_request_n <= 1'b1;
        st(`HBIA_ST_SREAD);
        w(4);
        chk(8'h01, {6'h0, bus_request_n, bus_busy_n});
        w(14);
        chk(8'h00, own);
        st(`HBIA_ST_PASSIVE);
        @(posedge clk);
        any_request_strap <= 1'b1;
        other_request_n <= 1'b0;
        w(6);
        chk(8'h03, own);
        @(posedge clk);
        other_request_n <= 1'b1;
        any_request_strap <= 1'b0;
    endtask : t_rel
    // Lane steering under a slow host
    task automatic t_lane();
        logic [7:0] el;
        @(posedge clk);
        slow <= 1'b1;
        st(`HBIA_ST_SREAD);
        w(24);
        chk(8'h01, {7'h0, processor_ready});
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            {byte_mode, internal_addr_bit0} <= 2'(i);
            addr_strobe_in <= i[0];
            w(4);
            el = {2'h0, !i[0], i[1], i[0], !(i[1] & i[0]), i[0], i[0]};
            chk(el, lv);
        end
        @(posedge clk);
        {byte_mode, internal_addr_bit0, addr_strobe_in, slow} <= 4'h0;
        st(`HBIA_ST_PASSIVE);
        w(6);
    endtask : t_lane
    task automatic t_brd();
        @(posedge clk);
        board_rst_n <= 1'b0;
        w(4);
        chk(8'h00, {7'h0, io_processor_rst_n});
        @(posedge clk);
        board_rst_n <= 1'b1;
        w(14);
        chk(8'h01, {7'h0, io_processor_rst_n});
    endtask : t_brd
    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        {board_rst_n, other_request_n, higher_request_n} = 3'h7;
        {bus_busy_in_n, port_ready} = 2'h3;
        {channel_attention_in, byte_mode, internal_addr_bit0} = 3'h0;
        {addr_strobe_in, any_request_strap, slow} = 3'h0;
        {cycle_status_2_n, cycle_status_1_n, cycle_status_0_n} = 3'h7;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_clk();
        t_ca();
        t_dec();
        t_rel();
        t_lane();
        t_brd();
        print_verdict();
    end
endmodule : tb
